// ==== rtl/remote_alarm_switch_config_pkg.sv ====
// constants and types for the switch-bank configuration and indicator block
package remote_alarm_switch_config_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register indices
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h1;
  localparam logic [3:0] MASK_OFS = 4'h2;
  localparam logic [3:0] CONFIG_OFS = 4'h3;
  localparam logic [3:0] PRINT_OFS = 4'h4;

  // control register fields
  localparam int CTRL_MAIL_BIT = 0;
  localparam int CTRL_LOGIN_BIT = 1;
  localparam int CTRL_FAULT_BIT = 2;
  localparam int CTRL_MAIL_MODE_BIT = 3;
  localparam int CTRL_SOFT_RESET_BIT = 4;
  localparam int CTRL_DISTRESS_MSG_BIT = 5;
  localparam int CTRL_RELAY_CLEAR_BIT = 6;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status / mask fields
  localparam int STAT_W = 4;
  localparam int STAT_PAPER_BIT = 0;
  localparam int STAT_DISTRESS_BIT = 1;
  localparam int STAT_WRAP_BIT = 2;
  localparam int STAT_SAMPLED_BIT = 3;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // switch decode
  localparam logic [2:0] LOCAL_PRINTER_CODE = 3'h7;
  localparam logic [6:0] WIDTH_NARROW = 7'h28;
  localparam logic [6:0] WIDTH_WIDE = 7'h50;
  localparam logic [7:0] LINE_FEED_CHAR = 8'h0A;
  localparam logic [7:0] SWITCH_RESET = 8'h00;

  // cycles after reset release before the synchronised bank is trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // switch bank, bit 0 is position 1
  typedef struct packed {
    logic width_40;
    logic dot_high;
    logic nmea_port;
    logic sounder_timeout;
    logic reverse;
    logic [2:0] addr_code;
  } switch_cfg_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN = 2'b11
  } load_state_t;

endpackage

// ==== rtl/sync2.sv ====
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_in;
      q_reg <= meta_reg;
    end
  end

  assign q_out = q_reg;

endmodule
`default_nettype wire

// ==== rtl/remote_alarm_switch_config.sv ====
// switch-bank configuration loader and indicator logic of the alarm/printer unit
// How it works
// - node address from switches 1-3, off,off,off is 1 up to 8.
// - decoded address 8 selects the local-printer role.
// - every other address selects the remote-alarm role.
// - switches read only at reset or soft reset, later changes ignored.
// - print line width 40 or 80 characters, lines wrap at that width.
// - paper-low indication follows the built-in paper sensor.
// - incoming-mail and login-status indications shown to the user.
// - remote power-on honoured only when the option jumper enables it.
// - in mail mode the unit-fault indicator shows mail, fault is lost.
// - enabled alarm relay fires on distress alert and distress message.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module remote_alarm_switch_config
  import remote_alarm_switch_config_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic irq_out,
  input wire logic [7:0] switch_bank_in,
  input wire logic paper_sensor_low_in,
  input wire logic remote_turn_on_in,
  input wire logic remote_on_enable_opt_in,
  input wire logic alarm_relay_enable_option_in,
  input wire logic distress_button_in,
  output logic config_valid_out,
  output logic [3:0] node_addr_out,
  output logic local_printer_out,
  output logic remote_alarm_out,
  output logic print_reverse_out,
  output logic sounder_timeout_out,
  output logic nmea_port_out,
  output logic dot_energy_high_out,
  output logic width_40_out,
  output logic [7:0] print_char_out,
  output logic print_valid_out,
  output logic line_wrap_out,
  output logic paper_low_out,
  output logic mail_ind_out,
  output logic login_ind_out,
  output logic unit_fault_indicator_out,
  output logic power_on_out,
  output logic alarm_relay_out
);

  // synchronised pins
  logic [7:0] switch_sync;
  logic [4:0] pins_sync;
  logic paper_low_sync;
  logic turn_on_sync;
  logic turn_on_en_sync;
  logic relay_en_sync;
  logic button_sync;

  sync2 #(
    .WIDTH(8)
  ) u_switch_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .d_in(switch_bank_in),
    .q_out(switch_sync)
  );

  sync2 #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .d_in({paper_sensor_low_in, remote_turn_on_in, remote_on_enable_opt_in,
           alarm_relay_enable_option_in, distress_button_in}),
    .q_out(pins_sync)
  );

  assign paper_low_sync = pins_sync[4];
  assign turn_on_sync = pins_sync[3];
  assign turn_on_en_sync = pins_sync[2];
  assign relay_en_sync = pins_sync[1];
  assign button_sync = pins_sync[0];

  // bus decode
  logic wr_ctrl;
  logic wr_mask;
  logic wr_print;
  logic rd_status;
  logic soft_reset;

  assign wr_ctrl = wr_in && (addr_in == CTRL_OFS);
  assign wr_mask = wr_in && (addr_in == MASK_OFS);
  assign wr_print = wr_in && (addr_in == PRINT_OFS);
  assign rd_status = rd_in && (addr_in == STATUS_OFS);
  assign soft_reset = wr_ctrl && wr_data_in[CTRL_SOFT_RESET_BIT];

  // load sequence
  load_state_t state_reg;
  load_state_t state_next;
  logic [1:0] settle_reg;
  switch_cfg_t cfg_reg;
  logic sample_now;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SETTLE: begin
        if (settle_reg == SETTLE_CYCLES) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_next = ST_RUN;
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_SETTLE;
      end
    endcase
    if (soft_reset) begin
      state_next = ST_SETTLE;
    end
  end

  assign sample_now = (state_reg == ST_SAMPLE);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // wait for the synchroniser to carry real switch levels
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      settle_reg <= 2'h0;
    end else if (state_reg != ST_SETTLE || soft_reset) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != SETTLE_CYCLES) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  // the only load point: running changes never reach cfg_reg
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg <= switch_cfg_t'(SWITCH_RESET);
    end else if (sample_now) begin
      cfg_reg <= switch_cfg_t'(switch_sync);
    end
  end

  // decode from the held copy
  logic [3:0] node_addr;
  logic is_local;
  logic [6:0] line_width;

  // position 3 is the low address bit
  assign node_addr = {1'b0, cfg_reg.addr_code[0], cfg_reg.addr_code[1], cfg_reg.addr_code[2]} + 4'h1;
  assign is_local = (cfg_reg.addr_code == LOCAL_PRINTER_CODE);
  assign line_width = cfg_reg.width_40 ? WIDTH_NARROW : WIDTH_WIDE;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      config_valid_out <= 1'b0;
    end else begin
      config_valid_out <= (state_next == ST_RUN);
    end
  end

  assign node_addr_out = node_addr;
  assign local_printer_out = is_local && config_valid_out;
  // the transceiver may still demote a local unit, that is its call
  assign remote_alarm_out = !is_local && config_valid_out;
  assign print_reverse_out = cfg_reg.reverse;
  assign sounder_timeout_out = cfg_reg.sounder_timeout;
  assign nmea_port_out = cfg_reg.nmea_port;
  assign dot_energy_high_out = cfg_reg.dot_high;
  assign width_40_out = cfg_reg.width_40;

  // control register
  logic [3:0] ctrl_reg;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= wr_data_in[3:0];
    end
  end

  // indicators
  assign mail_ind_out = ctrl_reg[CTRL_MAIL_BIT];
  assign login_ind_out = ctrl_reg[CTRL_LOGIN_BIT];
  // mail mode is set by software on the transceiver's command
  assign unit_fault_indicator_out = ctrl_reg[CTRL_MAIL_MODE_BIT] ?
                                    ctrl_reg[CTRL_MAIL_BIT] : ctrl_reg[CTRL_FAULT_BIT];
  assign paper_low_out = paper_low_sync;
  assign power_on_out = turn_on_sync && turn_on_en_sync;

  // printer column tracking, wraps at the configured width
  logic [6:0] column_reg;
  logic wrap_now;
  logic [7:0] print_char;

  assign print_char = wr_data_in[7:0];
  assign wrap_now = wr_print && config_valid_out && (print_char != LINE_FEED_CHAR) &&
                    (column_reg == line_width - 7'h1);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      column_reg <= 7'h0;
    end else if (soft_reset || !config_valid_out) begin
      column_reg <= 7'h0;
    end else if (wr_print) begin
      if (print_char == LINE_FEED_CHAR || wrap_now) begin
        column_reg <= 7'h0;
      end else begin
        column_reg <= column_reg + 7'h1;
      end
    end
  end

  // characters before the load finishes are dropped
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      print_char_out <= 8'h00;
      print_valid_out <= 1'b0;
      line_wrap_out <= 1'b0;
    end else begin
      print_valid_out <= wr_print && config_valid_out;
      line_wrap_out <= wrap_now;
      if (wr_print) begin
        print_char_out <= print_char;
      end
    end
  end

  // distress relay
  logic button_d_reg;
  logic paper_d_reg;
  logic distress_event;
  logic distress_msg;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      button_d_reg <= 1'b0;
      paper_d_reg <= 1'b0;
    end else begin
      button_d_reg <= button_sync;
      paper_d_reg <= paper_low_sync;
    end
  end

  assign distress_msg = wr_ctrl && wr_data_in[CTRL_DISTRESS_MSG_BIT];
  assign distress_event = (button_sync && !button_d_reg) || distress_msg;

  // a new alert beats a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_relay_out <= 1'b0;
    end else if (distress_event && relay_en_sync) begin
      alarm_relay_out <= 1'b1;
    end else if (!relay_en_sync || (wr_ctrl && wr_data_in[CTRL_RELAY_CLEAR_BIT])) begin
      alarm_relay_out <= 1'b0;
    end
  end

  // sticky status, cleared by reading it
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [STAT_W-1:0] status_set;

  assign status_set[STAT_PAPER_BIT] = paper_low_sync && !paper_d_reg;
  assign status_set[STAT_DISTRESS_BIT] = distress_event;
  assign status_set[STAT_WRAP_BIT] = wrap_now;
  assign status_set[STAT_SAMPLED_BIT] = sample_now;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= STAT_RESET;
    end else if (rd_status) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= wr_data_in[STAT_W-1:0];
    end
  end

  assign irq_out = |(status_reg & mask_reg);

  // read mux, registered so data stand in the cycle after the strobe
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (addr_in)
      CTRL_OFS: begin
        rd_mux = {12'h000, ctrl_reg};
      end
      STATUS_OFS: begin
        rd_mux = {12'h000, status_reg};
      end
      MASK_OFS: begin
        rd_mux = {12'h000, mask_reg};
      end
      CONFIG_OFS: begin
        rd_mux = {2'h0, config_valid_out, is_local, node_addr, cfg_reg};
      end
      PRINT_OFS: begin
        rd_mux = {9'h000, column_reg};
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
    end else if (rd_in) begin
      rd_data_out <= rd_mux;
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule
`default_nettype wire

// ==== verification/transceiver_model.sv ====
// transceiver-side model that sets the mail indication mode
`timescale 1ns/10ps
`default_nettype none
module transceiver_model #(
  parameter bit OWN_PRINTER = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic mail_indication_config_cmd_in,
  input wire logic local_role_in,
  output logic mail_mode_out,
  output logic printer_demoted_out
);
  // own printer attached: it stays the only local printer, the unit becomes alarm plus printer
  assign printer_demoted_out = OWN_PRINTER && local_role_in;
  // sticky: only the dedicated command turns mail mode on
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mail_mode_out <= 1'b0;
    end else if (mail_indication_config_cmd_in) begin
      mail_mode_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/remote_alarm_switch_config_asserts.sv ====
// port checker for the switch configuration block
`timescale 1ns/10ps
`default_nettype none
module remote_alarm_switch_config_asserts
  import remote_alarm_switch_config_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic paper_sensor_low_in,
  input wire logic alarm_relay_enable_option_in,
  input wire logic config_valid_out,
  input wire logic [3:0] node_addr_out,
  input wire logic local_printer_out,
  input wire logic remote_alarm_out,
  input wire logic print_valid_out,
  input wire logic line_wrap_out,
  input wire logic paper_low_out,
  input wire logic mail_ind_out,
  input wire logic login_ind_out,
  input wire logic unit_fault_indicator_out,
  input wire logic alarm_relay_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic ctrl_wr;
  assign ctrl_wr = wr_in && addr_in == CTRL_OFS;
  property p_local; local_printer_out == (config_valid_out && node_addr_out == 4'h8); endproperty
  a_local: assert property (p_local) else $error("local role wrong");
  property p_remote; remote_alarm_out == (config_valid_out && node_addr_out != 4'h8); endproperty
  a_remote: assert property (p_remote) else $error("remote role wrong");
  property p_hold; config_valid_out && $past(config_valid_out) |-> $stable(node_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("address moved while running");
  // two-flop sync, so only judged once the pin has been quiet
  property p_paper; $stable(paper_sensor_low_in) [*3] |-> paper_low_out == paper_sensor_low_in; endproperty
  a_paper: assert property (p_paper) else $error("paper low wrong");
  property p_ind; ctrl_wr |=> mail_ind_out == $past(wr_data_in[0]) && login_ind_out == $past(wr_data_in[1]); endproperty
  a_ind: assert property (p_ind) else $error("indicator wrong");
  property p_fault;
    ctrl_wr |=> unit_fault_indicator_out == ($past(wr_data_in[3]) ? $past(wr_data_in[0]) : $past(wr_data_in[2]));
  endproperty
  a_fault: assert property (p_fault) else $error("fault indicator wrong");
  property p_relay; !alarm_relay_enable_option_in [*4] |-> !alarm_relay_out; endproperty
  a_relay: assert property (p_relay) else $error("relay on while disabled");
  property p_pvalid; print_valid_out |-> $past(wr_in) && $past(addr_in) == PRINT_OFS; endproperty
  a_pvalid: assert property (p_pvalid) else $error("print pulse without write");
  property p_wrap; line_wrap_out |-> print_valid_out; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without char");
  c_local: cover property (local_printer_out);
  c_wrap: cover property (line_wrap_out);
  c_relay: cover property ($rose(alarm_relay_out));
endmodule
bind remote_alarm_switch_config remote_alarm_switch_config_asserts chk_i (.*);
`default_nettype wire

// ==== verification/remote_alarm_switch_config_tb_top.sv ====
// self-checking bench for the switch configuration block
`timescale 1ns/10ps
`default_nettype none
module remote_alarm_switch_config_tb_top import remote_alarm_switch_config_pkg::*;;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic [DATA_W-1:0] rd_data_out;
  logic [7:0] switch_bank_in = 8'h00;
  logic [7:0] print_char_out;
  logic [3:0] node_addr_out;
  logic paper_sensor_low_in = 1'b0, remote_turn_on_in = 1'b0, remote_on_enable_opt_in = 1'b0;
  logic alarm_relay_enable_option_in = 1'b0, distress_button_in = 1'b0, mail_indication_config_cmd_in = 1'b0;
  logic irq_out, config_valid_out, local_printer_out, remote_alarm_out, print_reverse_out, sounder_timeout_out;
  logic nmea_port_out, dot_energy_high_out, width_40_out, print_valid_out, line_wrap_out, paper_low_out;
  logic mail_ind_out, login_ind_out, unit_fault_indicator_out, power_on_out, alarm_relay_out, mail_mode_out;
  logic printer_demoted_out;
  int mismatches = 0, samples_checked = 0, seed = 57;
  remote_alarm_switch_config dut (.*);
  transceiver_model xcvr (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .mail_indication_config_cmd_in(mail_indication_config_cmd_in),
    .local_role_in(local_printer_out),
    .mail_mode_out(mail_mode_out),
    .printer_demoted_out(printer_demoted_out)
  );
  always #4 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask
  // bounded wait, a hang here is counted rather than looped on
  task automatic wait_valid;
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    while (config_valid_out !== 1'b1 && n < 20) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (config_valid_out !== 1'b1) mismatches++;
  endtask
  task automatic load(input logic [7:0] s);
    @(posedge clk_sys_in);
    switch_bank_in <= s;
    wr(CTRL_OFS, 16'h0010);
    wait_valid();
  endtask
  // position 1 is the address msb
  function automatic logic [3:0] exp_addr(input logic [7:0] s);
    return {1'b0, s[0], s[1], s[2]} + 4'h1;
  endfunction
  initial begin
    repeat (50000) @(posedge clk_sys_in);
    mismatches++;
    complete_run();
  end
  initial begin
    logic [15:0] d;
    logic [7:0] s;
    int w;
    s = 8'($random(seed));
    switch_bank_in = s;
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    wait_valid();
    chk("powerup addr", exp_addr(s), node_addr_out);
    for (int c = 0; c < 8; c++) begin
      s = 8'($random(seed));
      s[2:0] = 3'(c);
      load(s);
      rd(CONFIG_OFS, d);
      chk("config", {3'b001, exp_addr(s) == 4'h8, exp_addr(s), s}, d);
      chk("role", {exp_addr(s) == 4'h8, exp_addr(s) != 4'h8}, {local_printer_out, remote_alarm_out});
      chk("demoted", exp_addr(s) == 4'h8, printer_demoted_out);
      chk("options", s[7:3], {width_40_out, dot_energy_high_out, nmea_port_out, sounder_timeout_out, print_reverse_out});
    end
    @(posedge clk_sys_in);
    switch_bank_in <= ~s;
    repeat (6) @(posedge clk_sys_in);
    #1 chk("held addr", exp_addr(s), node_addr_out);
    for (int k = 0; k < 2; k++) begin
      load(k ? 8'h80 : 8'h00);
      w = k ? 40 : 80;
      for (int i = 0; i < w; i++) begin
        wr(PRINT_OFS, 16'h0041);
        chk("wrap", {6'h00, 1'b1, i == w - 1, 8'h41}, {6'h00, print_valid_out, line_wrap_out, print_char_out});
      end
    end
    repeat (3) wr(PRINT_OFS, 16'h0042);
    rd(PRINT_OFS, d);
    chk("column", 16'h0003, d);
    wr(PRINT_OFS, {8'h00, LINE_FEED_CHAR});
    rd(PRINT_OFS, d);
    chk("column lf", 16'h0000, d);
    rd(STATUS_OFS, d);
    chk("status wrap", 16'h000C, d);
    wr(MASK_OFS, 16'h0001);
    paper_sensor_low_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1 chk("paper irq", 16'h0003, {irq_out, paper_low_out});
    rd(STATUS_OFS, d);
    chk("status", 16'h0001, d & 16'h0001);
    chk("irq clr", 16'h0000, irq_out);
    for (int i = 0; i < 8; i++) begin
      mail_indication_config_cmd_in <= (i == 4);
      d = 16'($random(seed)) & 16'h0007;
      d[3] = mail_mode_out;
      wr(CTRL_OFS, d);
      chk("ind", {d[3] ? d[0] : d[2], d[1], d[0]}, {unit_fault_indicator_out, login_ind_out, mail_ind_out});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      remote_turn_on_in <= i[0];
      remote_on_enable_opt_in <= i[1];
      repeat (3) @(posedge clk_sys_in);
      #1 chk("power", i == 3, power_on_out);
    end
    alarm_relay_enable_option_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    distress_button_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    #1 chk("relay btn", 16'h0001, alarm_relay_out);
    wr(CTRL_OFS, 16'h0040);
    chk("relay clr", 16'h0000, alarm_relay_out);
    wr(CTRL_OFS, 16'h0020);
    chk("relay msg", 16'h0001, alarm_relay_out);
    alarm_relay_enable_option_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1 chk("relay off", 16'h0000, alarm_relay_out);
    rd(STATUS_OFS, d);
    chk("status distress", 16'h0002, d);
    rd(4'h7, d);
    chk("unmapped", 16'h0000, d);
    complete_run();
  end
endmodule
`default_nettype wire
